//--- spi_flash_pin_defines.vh
// constants for the multi-purpose pin selection logic of the serial flash
// assumes a single 40 mhz system clock samples every pin
`ifndef SPI_FLASH_PIN_DEFINES_VH
`define SPI_FLASH_PIN_DEFINES_VH

// system clock rate in mhz
`define CLK_MHZ            40
// least low time on a reset pin, nanoseconds
`define RESET_PULSE_NS     200
// least time rounded up to whole clock cycles
`define RESET_PULSE_CYC    ((`RESET_PULSE_NS * `CLK_MHZ + 999) / 1000)
// reset pulse counter width
`define RESET_CNT_W        8

// data width codes for the active command
`define WIDTH_SINGLE       2'h0
`define WIDTH_DUAL         2'h1
`define WIDTH_QUAD         2'h2

// lane numbers
`define LANE_DQ0           0
`define LANE_DQ1           1
`define LANE_DQ2           2
`define LANE_DQ3           3

`endif

//--- pin_sync.v
// two flip-flop synchroniser for a bundle of asynchronous levels
// assumes each bit is an independent level; no word coherency across bits
`timescale 1ns/1ps
module pin_sync
#(
   parameter WIDTH = 1,                 // number of bits
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}} // value held in reset
)
(
   // clock and reset
   input  wire             clk,
   input  wire             rst_n,
   // levels
   input  wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stage1;              // metastable stage, read only by stage2
   reg [WIDTH-1:0] stage2;              // settled copy

   // plain double register, no logic between stages
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         stage1 <= INIT;
         stage2 <= INIT;
      end
      else
      begin
         stage1 <= asyncIn;
         stage2 <= stage1;
      end
   end

   assign syncOut = stage2;

endmodule

//--- spi_flash_pin_function_select.v
// pin function selection for a serial multi-io flash: decides per shared pin
// whether it carries serial data, a data lane, write protect or reset
// assumes the command core runs on clk and supplies width and drive requests;
// serial clock and selects arrive asynchronously and are oversampled here
`timescale 1ns/1ps
`include "spi_flash_pin_defines.vh"

module spi_flash_pin_function_select
(
   // system
   input  wire       clk,
   input  wire       rst_n,
   // link control pins
   input  wire       sck,
   input  wire       csN,
   input  wire       hwRstN,               // dedicated reset pin
   input  wire       doNotUsePad,          // test pad, pulled low
   // shared pins, oe low while driving
   input  wire       serial_in_dq0_i,
   output reg        serial_in_dq0_o,
   output reg        serial_in_dq0_oeN,
   input  wire       serial_out_dq1_i,
   output reg        serial_out_dq1_o,
   output reg        serial_out_dq1_oeN,
   input  wire       wprot_dq2_i,
   output reg        wprot_dq2_o,
   output reg        wprot_dq2_oeN,
   input  wire       dq3_rst_n_i,
   output reg        dq3_rst_n_o,
   output reg        dq3_rst_n_oeN,
   // configuration bits from the register core
   input  wire       quad_enable_bit,
   input  wire       four_wire_instr_mode_bit,
   input  wire       pin_rst_enable_bit,
   input  wire       status_protect_nv_bit,
   // command core side
   input  wire [1:0] busWidth,             // width code of active phase
   input  wire       coreDrive,            // core is in an output phase
   input  wire [3:0] coreOutData,          // next nibble or bit to launch
   input  wire       write_regs_cmd,       // decoded register write command
   input  wire       write_any_reg_cmd,    // decoded any-register write
   output reg  [3:0] rxData,               // lanes sampled on rising edge
   output reg        rxValid,              // one pulse per rising edge while selected
   output reg        txAdvance,            // pulse: launched, give next
   output reg        regWriteIgnored,      // pulse: protected write dropped
   output reg        deviceReset,          // high while a filtered reset is held: return to standby
   output reg        writeProtectMode,     // lane2 pin acts as protect
   output reg        dq3ResetMode,         // lane3 pin acts as reset
   output reg        testFunctionActive    // do-not-use function on
);

   localparam integer            PULSE_INT = `RESET_PULSE_CYC;            // filter length, cycles
   localparam [`RESET_CNT_W-1:0] PULSE_CYC = PULSE_INT[`RESET_CNT_W-1:0]; // reset filter

   wire [3:0] padIn;                       // raw lane pins
   wire [3:0] laneIn;                      // synchronised lanes
   wire       sckS;                        // synchronised serial clock
   wire       csNS;                        // synchronised select
   wire       hwRstNS;                     // synchronised reset pin
   wire       dnuS;                        // synchronised test pad

   reg        sckLast;                     // previous serial clock sample
   reg  [`RESET_CNT_W-1:0] hwRstCnt;       // dedicated reset low time
   reg  [`RESET_CNT_W-1:0] dq3RstCnt;      // lane3 reset low time
   reg  [3:0] next_oeN;                    // lane drive enables, active low
   reg  [3:0] laneOut;                     // launched lane values

   wire sckRise;                           // rising edge seen
   wire sckFall;                           // falling edge seen
   wire selected;                          // chip select low
   wire quadLanes;                         // quad or four-wire mode
   wire hwRstHit;                          // reset pin held long enough
   wire dq3RstHit;                         // lane3 reset recognised
   wire protWrite;                         // register write while locked
   wire [3:0] laneUsed;                    // lanes active in this width

   assign padIn = {dq3_rst_n_i, wprot_dq2_i, serial_out_dq1_i, serial_in_dq0_i};

   // pins idle at their pull levels through reset so no edge or reset is invented;
   // the test pad idles low, so its stage must not start high
   pin_sync #(.WIDTH(8), .INIT(8'hf6)) u_sync
   (
      .clk     (clk),
      .rst_n   (rst_n),
      .asyncIn ({padIn, doNotUsePad, hwRstN, csN, sck}),
      .syncOut ({laneIn, dnuS, hwRstNS, csNS, sckS})
   );

   // edge detect on the settled copy only
   assign sckRise  = sckS & ~sckLast;
   assign sckFall  = ~sckS & sckLast;
   assign selected = ~csNS;
   assign quadLanes = quad_enable_bit | four_wire_instr_mode_bit;

   // the filters need the pin low for the whole pulse time
   assign hwRstHit  = (hwRstCnt == PULSE_CYC - 8'h01) & ~hwRstNS;
   // reset role on lane3 only when enabled; select high is needed to count
   assign dq3RstHit = (dq3RstCnt == PULSE_CYC - 8'h01) & ~laneIn[`LANE_DQ3];

   // locked register write: protect role, pin low, status protect set
   assign protWrite = (write_regs_cmd | write_any_reg_cmd)
                      & ~quad_enable_bit & status_protect_nv_bit
                      & ~laneIn[`LANE_DQ2];

   // which lanes a given width occupies while driving
   assign laneUsed = (busWidth == `WIDTH_QUAD) ? 4'hf :
                     (busWidth == `WIDTH_DUAL) ? 4'h3 : 4'h2;

   // lane drive decision per lane
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_lane
         always @*
         begin
            next_oeN[g] = 1'b1;
            if (selected && coreDrive && laneUsed[g])
            begin
               if (g == `LANE_DQ2)
                  next_oeN[g] = ~quad_enable_bit;
               else if (g == `LANE_DQ3)
                  next_oeN[g] = ~quadLanes;
               else
                  next_oeN[g] = 1'b0;
            end
         end
      end
   endgenerate

   // clock history
   always @(posedge clk)
   begin
      if (!rst_n)
         sckLast <= 1'b0;
      else
         sckLast <= sckS;
   end

   // dedicated reset pin filter; restarts whenever the pin rises
   always @(posedge clk)
   begin
      if (!rst_n || hwRstNS)
         hwRstCnt <= {`RESET_CNT_W{1'b0}};
      else if (hwRstCnt != PULSE_CYC - 8'h01)
         hwRstCnt <= hwRstCnt + 8'h01;
   end

   // lane3 reset filter, counted only while the pin holds the reset role
   always @(posedge clk)
   begin
      if (!rst_n || !pin_rst_enable_bit || selected || laneIn[`LANE_DQ3])
         dq3RstCnt <= {`RESET_CNT_W{1'b0}};
      else if (dq3RstCnt != PULSE_CYC - 8'h01)
         dq3RstCnt <= dq3RstCnt + 8'h01;
   end

   // receive: sample the lanes of the active width on the rising serial clock while selected
   always @(posedge clk)
   begin
      if (!rst_n || deviceReset)
      begin
         rxData  <= 4'h0;
         rxValid <= 1'b0;
      end
      else
      begin
         rxValid <= sckRise & selected;
         if (sckRise && selected)
         begin
            // single commands read only the serial input lane
            if (busWidth == `WIDTH_SINGLE)
               rxData <= {3'h0, laneIn[`LANE_DQ0]};
            else
               rxData <= laneIn & laneUsed;
         end
      end
   end

   // transmit: launch new lane values after each falling serial clock while selected and in an output phase
   always @(posedge clk)
   begin
      if (!rst_n || deviceReset)
      begin
         laneOut   <= 4'h0;
         txAdvance <= 1'b0;
      end
      else
      begin
         txAdvance <= sckFall & selected & coreDrive;
         if (sckFall && selected && coreDrive)
         begin
            // single output leaves on the serial out lane
            if (busWidth == `WIDTH_SINGLE)
               laneOut <= {2'h0, coreOutData[0], 1'b0};
            else
               laneOut <= coreOutData;
         end
      end
   end

   // pin drivers; deselect releases every lane at once
   always @(posedge clk)
   begin
      if (!rst_n || deviceReset)
      begin
         serial_in_dq0_o    <= 1'b0;
         serial_in_dq0_oeN  <= 1'b1;
         serial_out_dq1_o   <= 1'b0;
         serial_out_dq1_oeN <= 1'b1;
         wprot_dq2_o        <= 1'b0;
         wprot_dq2_oeN      <= 1'b1;
         dq3_rst_n_o        <= 1'b0;
         dq3_rst_n_oeN      <= 1'b1;
      end
      else
      begin
         serial_in_dq0_o    <= laneOut[`LANE_DQ0];
         serial_in_dq0_oeN  <= next_oeN[`LANE_DQ0];
         serial_out_dq1_o   <= laneOut[`LANE_DQ1];
         serial_out_dq1_oeN <= next_oeN[`LANE_DQ1];
         wprot_dq2_o        <= laneOut[`LANE_DQ2];
         wprot_dq2_oeN      <= next_oeN[`LANE_DQ2];
         dq3_rst_n_o        <= laneOut[`LANE_DQ3];
         dq3_rst_n_oeN      <= next_oeN[`LANE_DQ3];
      end
   end

   // role flags and event pulses
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         regWriteIgnored    <= 1'b0;
         deviceReset        <= 1'b0;
         writeProtectMode   <= 1'b0;
         dq3ResetMode       <= 1'b0;
         testFunctionActive <= 1'b0;
      end
      else
      begin
         // either reset source forces standby; stays high while the pin is held
         deviceReset <= hwRstHit | dq3RstHit;
         // host must hold the pin driven here; a float reads as pulled high
         writeProtectMode <= ~quad_enable_bit & status_protect_nv_bit;
         dq3ResetMode <= pin_rst_enable_bit & (~quad_enable_bit | csNS);
         // deselected commands are ignored, so no drop report either
         regWriteIgnored <= protWrite & selected;
         // test function follows its pad; low keeps it off
         testFunctionActive <= dnuS;
      end
   end

endmodule

//--- spi_flash_pin_function_select_end.v
`timescale 1ns/1ps
// empty design file: holds no module
// assumes all logic lives in the main file and the synchroniser

//--- spi_flash_pin_function_select_assertions.sv
// checker for the pin function select block
// assumes one clk domain and a synchronous active-low rst_n
`timescale 1ns/1ps
module spi_flash_pin_function_select_checker
(
   // system
   input logic clk,
   input logic rst_n,
   // pins
   input logic csN,
   input logic hwRstN,
   input logic doNotUsePad,
   input logic dq3_rst_n_i,
   input logic serial_in_dq0_oeN,
   input logic serial_out_dq1_oeN,
   input logic wprot_dq2_oeN,
   input logic dq3_rst_n_oeN,
   // configuration
   input logic quad_enable_bit,
   input logic four_wire_instr_mode_bit,
   input logic pin_rst_enable_bit,
   input logic status_protect_nv_bit,
   // core side
   input logic rxValid,
   input logic regWriteIgnored,
   input logic deviceReset,
   input logic writeProtectMode,
   input logic dq3ResetMode,
   input logic testFunctionActive
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // reset pin held low well past the pulse filter
   sequence hwLongLow;
      (!hwRstN)[*8] ##1 (!hwRstN)[*6];
   endsequence
   // long deselect so the synced select has settled
   sequence deselected;
      csN[*5];
   endsequence
   chk_wp_mode_on: assert property (!quad_enable_bit && status_protect_nv_bit |=> writeProtectMode)
      else $error("protect mode missing");
   chk_quad_no_wp: assert property (quad_enable_bit |=> !writeProtectMode)
      else $error("protect mode in quad");
   chk_dq2_no_drive: assert property ((!quad_enable_bit)[*2] |-> wprot_dq2_oeN)
      else $error("lane2 driven outside quad");
   chk_dq3_no_drive: assert property ((!quad_enable_bit && !four_wire_instr_mode_bit)[*2]
      |-> dq3_rst_n_oeN)
      else $error("lane3 driven outside quad");
   chk_desel_release: assert property (deselected |-> serial_in_dq0_oeN && serial_out_dq1_oeN
      && wprot_dq2_oeN && dq3_rst_n_oeN && !rxValid)
      else $error("activity while deselected");
   chk_rst_mode_on: assert property (pin_rst_enable_bit && !quad_enable_bit |=> dq3ResetMode)
      else $error("lane3 reset mode missing");
   chk_rst_mode_off: assert property (!pin_rst_enable_bit |=> !dq3ResetMode)
      else $error("lane3 reset mode while disabled");
   chk_hw_reset: assert property (hwLongLow |-> deviceReset)
      else $error("reset pin ignored");
   chk_short_pulse: assert property ($rose(deviceReset) |-> !$past(hwRstN, 8)
      || (!$past(dq3_rst_n_i, 8) && $past(csN, 8) && $past(pin_rst_enable_bit, 8)))
      else $error("reset without qualified pulse");
   chk_ignore_cause: assert property (regWriteIgnored |-> $past(status_protect_nv_bit)
      && !$past(quad_enable_bit))
      else $error("write dropped without protection");
   chk_pad_idle: assert property ((!doNotUsePad)[*4] |-> !testFunctionActive)
      else $error("test function active");
endmodule

bind spi_flash_pin_function_select spi_flash_pin_function_select_checker u_chk
(
   .clk, .rst_n, .csN, .hwRstN, .doNotUsePad, .dq3_rst_n_i, .serial_in_dq0_oeN,
   .serial_out_dq1_oeN, .wprot_dq2_oeN, .dq3_rst_n_oeN, .quad_enable_bit,
   .four_wire_instr_mode_bit, .pin_rst_enable_bit, .status_protect_nv_bit, .rxValid,
   .regWriteIgnored, .deviceReset, .writeProtectMode, .dq3ResetMode, .testFunctionActive
);

//--- spi_host_model.sv
// host controller model: serial clock, select and lane drive
// assumes mode 0, clock idle low outside frames
`timescale 1ns/1ps
module spi_host_model
(
   input  wire       clk,
   output reg        sck,
   output reg        csN,
   output reg  [3:0] hostOut,
   output reg  [3:0] hostEn
);
   initial
   begin
      sck = 1'b0;
      csN = 1'b1;
      hostOut = 4'hf;
      hostEn = 4'h0;
   end
   // select level change, then settle time
   task sel(input s);
   begin
      csN <= s;
      repeat (6) @(posedge clk);
   end
   endtask
   // one 200 ns period; caller keeps the protect lane driven in writes
   task clkbit(input [3:0] v, input [3:0] en);
   begin
      hostOut <= v;
      hostEn <= en;
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      sck <= 1'b0;
   end
   endtask
endmodule

//--- spi_flash_pin_function_select_tb.sv
// testbench for the pin function select block
// assumes host model drives pins; bench plays the command core
`timescale 1ns/1ps
module spi_flash_pin_function_select_tb;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg hwRstN = 1'b1;
   reg doNotUsePad = 1'b0;
   reg qe = 1'b0, fw = 1'b0, re = 1'b0, sp = 1'b0;
   reg [1:0] busWidth = 2'h0;
   reg coreDrive = 1'b0;
   reg [3:0] coreOut = 4'h0;
   reg wr = 1'b0, wa = 1'b0;
   wire sck, csN, rxValid, txAdvance, ign, devRst, wpMode, rstMode, tfa;
   wire [3:0] hostOut, hostEn, oeN, dOut, rxData;
   // released lanes: dq2/dq3 pulled up, dq0/dq1 flip
   wire [3:0] pin = (~oeN & dOut) | (oeN & hostEn & hostOut) | (oeN & ~hostEn & {2'h3, ~hostOut[1:0]});
   integer n_fail = 0, cmp_count = 0, nRx = 0, nIgn = 0, nRst = 0, nTx = 0, i, k;
   reg [3:0] lastRx = 4'h0;
   always #12.5 clk = ~clk;
   spi_host_model u_host (.clk(clk), .sck(sck), .csN(csN), .hostOut(hostOut), .hostEn(hostEn));
   spi_flash_pin_function_select u_dut (.clk(clk), .rst_n(rst_n), .sck(sck), .csN(csN),
      .hwRstN(hwRstN), .doNotUsePad(doNotUsePad), .serial_in_dq0_i(pin[0]),
      .serial_in_dq0_o(dOut[0]), .serial_in_dq0_oeN(oeN[0]), .serial_out_dq1_i(pin[1]),
      .serial_out_dq1_o(dOut[1]), .serial_out_dq1_oeN(oeN[1]), .wprot_dq2_i(pin[2]),
      .wprot_dq2_o(dOut[2]), .wprot_dq2_oeN(oeN[2]), .dq3_rst_n_i(pin[3]),
      .dq3_rst_n_o(dOut[3]), .dq3_rst_n_oeN(oeN[3]), .quad_enable_bit(qe),
      .four_wire_instr_mode_bit(fw), .pin_rst_enable_bit(re), .status_protect_nv_bit(sp),
      .busWidth(busWidth), .coreDrive(coreDrive), .coreOutData(coreOut), .write_regs_cmd(wr),
      .write_any_reg_cmd(wa), .rxData(rxData), .rxValid(rxValid), .txAdvance(txAdvance),
      .regWriteIgnored(ign), .deviceReset(devRst), .writeProtectMode(wpMode),
      .dq3ResetMode(rstMode), .testFunctionActive(tfa));
   // event counters for pulses
   always @(posedge clk)
   begin
      if (rxValid === 1'b1) begin lastRx <= rxData; nRx <= nRx + 1; end
      if (ign === 1'b1) nIgn <= nIgn + 1;
      if (devRst === 1'b1) nRst <= nRst + 1;
      if (txAdvance === 1'b1) nTx <= nTx + 1;
   end
   task w(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task check(input [79:0] nm, input [3:0] seen, input [3:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
         n_fail = n_fail + 1;
         $display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
      end
   end
   endtask
   task summarize;
   begin
      if (n_fail == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   // watchdog, far beyond the few hundred cycles needed
   initial
   begin
      w(20000);
      n_fail = n_fail + 1;
      summarize;
   end
   initial
   begin
      w(10);
      rst_n <= 1'b1;
      for (i = 0; i < 4; i = i + 1)
      begin
         w(1);
         {qe, sp, re} <= {i[0], i[1], i[1]};
         w(3);
         check("wpMode", wpMode, {3'h0, !i[0] && i[1]});
         check("rstMode", rstMode, {3'h0, i[1]});
      end
      w(1);
      {qe, sp, re, busWidth} <= 5'h0;
      u_host.sel(1'b0);
      u_host.clkbit(4'h1, 4'h5); w(2); check("rx1", lastRx, 4'h1);
      u_host.clkbit(4'h0, 4'h5); w(2); check("rx0", lastRx, 4'h0);
      busWidth <= 2'h1;
      u_host.clkbit(4'hf, 4'hf); w(2); check("rxDual", lastRx, 4'h3);
      busWidth <= 2'h0;
      coreDrive <= 1'b1;
      coreOut <= 4'h1;
      u_host.clkbit(4'h0, 4'h5); w(8);
      check("oeSingle", oeN, 4'hd);
      check("so", {3'h0, dOut[1]}, 4'h1);
      {coreDrive, qe, re, busWidth} <= 5'h0e; // receive only: quad, lane3 reset enabled
      u_host.clkbit(4'ha, 4'hf); w(2); check("rxQuad", lastRx, 4'ha);
      check("rstSel", {3'h0, rstMode}, 4'h0);
      coreDrive <= 1'b1;
      coreOut <= 4'h6;
      k = nTx;
      u_host.clkbit(4'h0, 4'h0); w(8);
      check("oeQuad", oeN, 4'h0);
      check("txAdv", {3'h0, nTx > k}, 4'h1);
      check("txQuad", dOut, 4'h6);
      {qe, fw} <= 2'h1;
      u_host.clkbit(4'h0, 4'h0); w(8); check("oeFour", {3'h0, oeN[3]}, 4'h0);
      u_host.sel(1'b1);
      check("oeDesel", oeN, 4'hf);
      i = nRx;
      k = nTx;
      // lane3 kept high: a low lane3 with select high would start a reset
      u_host.clkbit(4'hd, 4'hf); w(4); check("rxDesel", {3'h0, nRx != i}, 4'h0);
      check("txDesel", {3'h0, nTx != k}, 4'h0);
      {coreDrive, fw, sp, re} <= 4'h2;
      u_host.sel(1'b0);
      i = nIgn;
      wr <= 1'b1;
      u_host.clkbit(4'h0, 4'h4); w(4); wr <= 1'b0;
      check("ignLow", {3'h0, nIgn > i}, 4'h1);
      u_host.clkbit(4'h4, 4'h4); // protect pin high and settled before the next write
      i = nIgn;
      wa <= 1'b1;
      u_host.clkbit(4'h4, 4'h4); w(4); wa <= 1'b0;
      check("ignHigh", {3'h0, nIgn != i}, 4'h0);
      u_host.sel(1'b1);
      i = nRst; hwRstN <= 1'b0; w(4); hwRstN <= 1'b1; w(12);
      check("shortRst", {3'h0, nRst != i}, 4'h0);
      hwRstN <= 1'b0; w(20); hwRstN <= 1'b1; w(4);
      check("longRst", {3'h0, nRst > i}, 4'h1);
      i = nRst; re <= 1'b1; u_host.clkbit(4'h0, 4'h8); w(12);
      check("lane3Rst", {3'h0, nRst > i}, 4'h1);
      re <= 1'b0; w(4); // let the held lane3 reset drain first
      i = nRst; u_host.clkbit(4'h0, 4'h8); w(12);
      check("lane3Off", {3'h0, nRst != i}, 4'h0);
      doNotUsePad <= 1'b1; w(4); check("padOn", {3'h0, tfa}, 4'h1);
      doNotUsePad <= 1'b0; w(4); check("padOff", {3'h0, tfa}, 4'h0);
      summarize;
   end
endmodule
